// ===== lpc_pkg.sv
/*
  lpc_pkg: register map, field positions, reset values and timing
  constants for the LIN physical layer control register bank.
  Assumes a classic Wishbone slave with 32-bit data, one register per word.
*/
package lpc_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_PORT_DATA = 3'h0;
  localparam logic [2:0] IDX_PHY_CONTROL = 3'h1;
  localparam logic [2:0] IDX_FACTORY_TEST_A = 3'h2;
  localparam logic [2:0] IDX_SLEW_RATE_SELECT = 3'h3;
  localparam logic [2:0] IDX_FACTORY_TEST_B = 3'h4;
  localparam logic [2:0] IDX_PHY_STATUS = 3'h5;
  localparam logic [2:0] IDX_IRQ_ENABLE = 3'h6;
  localparam logic [2:0] IDX_IRQ_FLAGS = 3'h7;
  localparam int ADDR_W = 5;
  localparam int REG_W = 8;
  // field positions
  localparam int BIT_RX_SENSE = 0;
  localparam int BIT_TX_DRIVE = 1;
  localparam int BIT_PULLUP_STRONG = 0;
  localparam int BIT_WAKE_ENABLE = 1;
  localparam int BIT_RECEIVE_ONLY = 2;
  localparam int BIT_PHY_ENABLE = 3;
  localparam int BIT_SLEW_LSB = 0;
  localparam int BIT_SLEW_LOCK = 7;
  localparam int BIT_OC_STATUS = 0;
  localparam int BIT_OC_IRQ_EN = 7;
  localparam int BIT_OC_FLAG = 0;
  // reset values
  localparam logic RST_TX_DRIVE = 1'h1;
  localparam logic RST_PHY_ENABLE = 1'h0;
  localparam logic RST_RECEIVE_ONLY = 1'h0;
  localparam logic RST_WAKE_ENABLE = 1'h1;
  localparam logic RST_PULLUP_STRONG = 1'h1;
  localparam logic [7:0] RST_FACTORY_TEST = 8'h00;
  // slew encodings
  typedef enum logic [1:0] {
    LPC_SLEW_NORMAL = 2'b00,
    LPC_SLEW_SLOW = 2'b01,
    LPC_SLEW_FAST = 2'b10,
    LPC_SLEW_RSVD = 2'b11
  } lpc_slew_e;
  // slew synchronisation time into the analog stage
  localparam int CLK_MHZ = 250;
  localparam int SLEW_SYNC_NS = 16;
  localparam int SLEW_SYNC_CYC = (SLEW_SYNC_NS * CLK_MHZ + 999) / 1000;
endpackage : lpc_pkg

// ===== lpc_regs.sv
/*
  lpc_regs: control and status register bank of a single-wire LIN
  physical layer. Assumes a classic Wishbone master on clk_i, the
  analog transceiver outputs arriving asynchronously, and a factory
  test strap from the chip level.
*/
// The Wishbone slave port is this design's own decision.
// Behaviour
// - tx drive bit sets transceiver transmit level
// - rx sense bit reads live receive output
// - enable zero means shutdown, weak pull-up only
// - over-current forces receive-only, blocks its writes
// - normal mode lets software write receive-only
// - wake enable gates standby wake detection
// - strong pull-up only with select and enable
// - slew write sets lock until synchronized
// - slew writes discarded while lock reads one
// - slew codes normal, slow, fast, reserved
// - test registers writable only in factory mode
// - registers decoded at base plus eight offsets
// - over-current status read-only, transmitter off
// - change flag set on change, write-one clears
// - interrupt when flag and enable both set
// - over-current or bit moves to receive-only
`timescale 1ns/10ps
`default_nettype none
module lpc_regs
  import lpc_pkg::*;
#(
  parameter int SYNC_CYC = lpc_pkg::SLEW_SYNC_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [lpc_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // transceiver and chip-level inputs (asynchronous)
  input wire logic phy_rx_output_i,
  input wire logic overcurrent_i,
  input wire logic factory_mode_i,
  input wire logic standby_i,
  input wire logic bus_wake_i,
  // transceiver controls
  output logic phy_tx_input_o,
  output logic tx_enable_o,
  output logic rx_enable_o,
  output logic pullup_strong_o,
  output logic wake_detect_en_o,
  output logic wake_o,
  output lpc_pkg::lpc_slew_e slew_o,
  output logic [7:0] test_a_o,
  output logic [7:0] test_b_o,
  output logic irq_o
);
  import lpc_pkg::*;

  initial begin
    if (SYNC_CYC < 1 || SYNC_CYC > 255) $error("SYNC_CYC out of range");
  end

  // input synchronisers: stage one read only by stage two
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
    end else begin
      s1_ff <= {bus_wake_i, standby_i, factory_mode_i, overcurrent_i, phy_rx_output_i};
      s2_ff <= s1_ff;
    end
  end
  wire rx_sync = s2_ff[0];
  wire oc_sync = s2_ff[1];
  wire factory_sync = s2_ff[2];
  wire standby_sync = s2_ff[3];
  wire wake_sync = s2_ff[4];

  // bus decode
  logic ack_ff;
  logic err_ff;
  // an error answer also ends the cycle, so it must block a second take
  wire req = cyc_i & stb_i & ~ack_ff & ~err_ff;
  wire lane0 = sel_i[0];
  wire in_range = (adr_i[1:0] == 2'h0);
  wire [2:0] idx = adr_i[4:2];
  wire wr = req & we_i & in_range & lane0;
  wire [7:0] wd = dat_i[7:0];

  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] target);
    wr_hit = (a == target);
  endfunction : wr_hit

  // registers
  logic tx_drive_ff, phy_enable_ff, receive_only_ff, wake_enable_ff, pullup_ff;
  logic [1:0] slew_ff;
  logic slew_lock_ff;
  logic [7:0] sync_cnt_ff;
  logic [7:0] test_a_ff, test_b_ff;
  logic oc_irq_en_ff, oc_flag_ff, oc_prev_ff;
  logic [31:0] dat_ff;

  wire wr_port = wr & wr_hit(idx, IDX_PORT_DATA);
  wire wr_ctrl = wr & wr_hit(idx, IDX_PHY_CONTROL);
  wire wr_slew = wr & wr_hit(idx, IDX_SLEW_RATE_SELECT) & ~slew_lock_ff;
  wire wr_ta = wr & wr_hit(idx, IDX_FACTORY_TEST_A) & factory_sync;
  wire wr_tb = wr & wr_hit(idx, IDX_FACTORY_TEST_B) & factory_sync;
  wire wr_ie = wr & wr_hit(idx, IDX_IRQ_ENABLE);
  wire wr_if = wr & wr_hit(idx, IDX_IRQ_FLAGS);
  wire oc_change = oc_sync ^ oc_prev_ff;

  // receive-only: forced by over-current, writes blocked meanwhile
  wire nxt_receive_only = oc_sync ? 1'b1 :
    (wr_ctrl ? wd[BIT_RECEIVE_ONLY] : receive_only_ff);
  // set wins over the write-one clear
  wire nxt_oc_flag = oc_change | (oc_flag_ff & ~(wr_if & wd[BIT_OC_FLAG]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_drive_ff <= RST_TX_DRIVE;
      phy_enable_ff <= RST_PHY_ENABLE;
      receive_only_ff <= RST_RECEIVE_ONLY;
      wake_enable_ff <= RST_WAKE_ENABLE;
      pullup_ff <= RST_PULLUP_STRONG;
      test_a_ff <= RST_FACTORY_TEST;
      test_b_ff <= RST_FACTORY_TEST;
      oc_irq_en_ff <= 1'b0;
    end else begin
      if (wr_port) tx_drive_ff <= wd[BIT_TX_DRIVE];
      if (wr_ctrl) begin
        phy_enable_ff <= wd[BIT_PHY_ENABLE];
        wake_enable_ff <= wd[BIT_WAKE_ENABLE];
        pullup_ff <= wd[BIT_PULLUP_STRONG];
      end
      receive_only_ff <= nxt_receive_only;
      if (wr_ta) test_a_ff <= wd;
      if (wr_tb) test_b_ff <= wd;
      if (wr_ie) oc_irq_en_ff <= wd[BIT_OC_IRQ_EN];
    end
  end

  // over-current tracking; prev starts clear so a stuck fault flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_prev_ff <= 1'b0;
      oc_flag_ff <= 1'b0;
    end else begin
      oc_prev_ff <= oc_sync;
      oc_flag_ff <= nxt_oc_flag;
    end
  end

  // slew select with lock held while the new value settles in the analog stage
  wire [7:0] nxt_sync_cnt = wr_slew ? 8'(SYNC_CYC) :
    (sync_cnt_ff != 8'h00 ? sync_cnt_ff - 8'h01 : 8'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slew_ff <= LPC_SLEW_NORMAL;
      slew_lock_ff <= 1'b0;
      sync_cnt_ff <= 8'h00;
    end else begin
      if (wr_slew) slew_ff <= wd[BIT_SLEW_LSB +: 2];
      sync_cnt_ff <= nxt_sync_cnt;
      slew_lock_ff <= (nxt_sync_cnt != 8'h00);
    end
  end

  // read mux; unused bits are zero
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    case (idx)
      IDX_PORT_DATA: begin
        rd[BIT_TX_DRIVE] = tx_drive_ff;
        rd[BIT_RX_SENSE] = rx_sync;
      end
      IDX_PHY_CONTROL: begin
        rd[BIT_PHY_ENABLE] = phy_enable_ff;
        rd[BIT_RECEIVE_ONLY] = receive_only_ff;
        rd[BIT_WAKE_ENABLE] = wake_enable_ff;
        rd[BIT_PULLUP_STRONG] = pullup_ff;
      end
      IDX_FACTORY_TEST_A: rd = test_a_ff;
      IDX_SLEW_RATE_SELECT: begin
        rd[BIT_SLEW_LOCK] = slew_lock_ff;
        rd[BIT_SLEW_LSB +: 2] = slew_ff;
      end
      IDX_FACTORY_TEST_B: rd = test_b_ff;
      IDX_PHY_STATUS: rd[BIT_OC_STATUS] = oc_sync;
      IDX_IRQ_ENABLE: rd[BIT_OC_IRQ_EN] = oc_irq_en_ff;
      IDX_IRQ_FLAGS: rd[BIT_OC_FLAG] = oc_flag_ff;
      default: rd = 8'h00;
    endcase
  end

  // one wait state: ack the cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & in_range;
      err_ff <= req & ~in_range;
      if (req & ~we_i & in_range) dat_ff <= {24'h00_0000, rd};
    end
  end
  assign ack_o = ack_ff;
  assign err_o = err_ff;
  assign dat_o = dat_ff;

  // transceiver side
  wire active = phy_enable_ff;
  assign tx_enable_o = active & ~receive_only_ff & ~oc_sync & ~standby_sync;
  assign rx_enable_o = active;
  assign phy_tx_input_o = tx_drive_ff;
  assign pullup_strong_o = pullup_ff & phy_enable_ff;
  assign wake_detect_en_o = active & standby_sync & wake_enable_ff;
  assign wake_o = wake_detect_en_o & wake_sync;
  assign slew_o = lpc_slew_e'(slew_ff);
  assign test_a_o = test_a_ff;
  assign test_b_o = test_b_ff;
  assign irq_o = oc_flag_ff & oc_irq_en_ff;
endmodule : lpc_regs
`default_nettype wire

// ===== lpc_bus_model.sv
/* lpc_bus_model: single-wire bus and transceiver stage seen by lpc_regs.
   Assumes a testbench short command; bus idles recessive via the pull-up. */
`timescale 1ns/10ps
`default_nettype none
module lpc_bus_model (
  // transceiver controls
  input wire logic tx_i,
  input wire logic tx_en_i,
  // fault command
  input wire logic short_i,
  // sensed back
  output logic rx_o,
  output logic oc_o
);
  // a short to supply wins over any dominant drive
  assign oc_o = short_i;
  assign rx_o = short_i | !(tx_en_i & !tx_i);
endmodule : lpc_bus_model
`default_nettype wire

// ===== lpc_regs_checker.sv
/* lpc_regs_checker: port-level assertions for lpc_regs.
   Assumes it is bound to lpc_regs and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module lpc_regs_checker
  import lpc_pkg::*;
(
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [lpc_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic err_o,
  // transceiver side
  input wire logic overcurrent_i,
  input wire logic phy_tx_input_o,
  input wire logic tx_enable_o,
  input wire logic rx_enable_o,
  input wire logic pullup_strong_o,
  input wire logic wake_detect_en_o,
  input wire logic wake_o,
  input wire lpc_pkg::lpc_slew_e slew_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i & stb_i & !ack_o & !err_o;
  wire wr0 = take & we_i & sel_i[0];
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_err_once; err_o |=> !err_o; endproperty
  a_err_once: assert property (p_err_once) else $error("err too long");
  property p_answer; take |=> ack_o ^ err_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_misalign; take && adr_i[1:0] != 2'h0 |=> err_o && !ack_o; endproperty
  a_misalign: assert property (p_misalign) else $error("no err");
  property p_tx; wr0 && adr_i == 5'h00 |=> phy_tx_input_o == $past(dat_i[1]); endproperty
  a_tx: assert property (p_tx) else $error("tx level");
  property p_shut; !rx_enable_o |-> !tx_enable_o && !pullup_strong_o && !wake_detect_en_o; endproperty
  a_shut: assert property (p_shut) else $error("shutdown");
  // two-flop sync lag, one spare cycle
  property p_oc; overcurrent_i [*4] |-> !tx_enable_o; endproperty
  a_oc: assert property (p_oc) else $error("tx on in fault");
  property p_wake; wake_o |-> wake_detect_en_o; endproperty
  a_wake: assert property (p_wake) else $error("wake gate");
  property p_slew; $changed(slew_o) |-> $past(wr0 && adr_i == 5'h0C); endproperty
  a_slew: assert property (p_slew) else $error("slew change");
  c_write: cover property (wr0 ##1 ack_o);
  c_err: cover property (err_o);
  c_wake: cover property (wake_o);
endmodule : lpc_regs_checker
`default_nettype wire

// ===== lpc_regs_tb_top.sv
/* lpc_regs_tb_top: directed register tests of lpc_regs over classic Wishbone.
   Assumes lpc_pkg, lpc_bus_model and lpc_regs_checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module lpc_regs_tb_top;
  import lpc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [4:0] adr_i = 5'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic factory_mode_i = 1'b0;
  logic standby_i = 1'b0;
  logic bus_wake_i = 1'b0;
  logic short = 1'b0;
  logic [31:0] dat_o, rd;
  logic ack_o, err_o, ge, phy_rx_output_i, overcurrent_i, phy_tx_input_o, tx_enable_o, rx_enable_o;
  logic pullup_strong_o, wake_detect_en_o, wake_o, irq_o;
  logic [7:0] test_a_o, test_b_o;
  lpc_slew_e slew_o;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // longer lock so a read can catch it
  lpc_regs #(.SYNC_CYC(8)) dut (.*);
  lpc_bus_model u_bus (.tx_i(phy_tx_input_o), .tx_en_i(tx_enable_o), .short_i(short),
    .rx_o(phy_rx_output_i), .oc_o(overcurrent_i));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wb(logic w, logic [4:0] a, logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (!(ack_o | err_o)) @(posedge clk_i);
    rd = dat_o;
    ge = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rdc(string n, logic [4:0] a, logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rd);
  endtask : rdc
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    tick(4);
    rst_i <= 1'b0;
    // receive level needs two edges through the synchroniser
    tick(3);
    rdc("pd", 5'h00, 8'h03);
    rdc("pc", 5'h04, 8'h03);
    wb(1'b1, 5'h04, 8'hF9);
    chk("pu", 1, pullup_strong_o);
    rdc("pc", 5'h04, 8'h09);
    wb(1'b1, 5'h04, 8'h08);
    chk("pu", 0, pullup_strong_o);
    wb(1'b1, 5'h00, 8'hFC);
    chk("tx", 0, phy_tx_input_o);
    tick(3);
    rdc("pd", 5'h00, 8'h00);
    wb(1'b1, 5'h04, 8'h0C);
    chk("txe", 0, tx_enable_o);
    wb(1'b1, 5'h04, 8'h08);
    chk("txe", 1, tx_enable_o);
    $display("test basic done");
    short <= 1'b1;
    tick(6);
    rdc("st", 5'h14, 8'h01);
    chk("txe", 0, tx_enable_o);
    wb(1'b1, 5'h04, 8'h08);
    rdc("pc", 5'h04, 8'h0C);
    wb(1'b1, 5'h1C, 8'h01);
    wb(1'b1, 5'h18, 8'h80);
    chk("irq", 0, irq_o);
    short <= 1'b0;
    tick(6);
    chk("irq", 1, irq_o);
    wb(1'b1, 5'h1C, 8'h00);
    rdc("if", 5'h1C, 8'h01);
    wb(1'b1, 5'h1C, 8'h01);
    chk("irq", 0, irq_o);
    wb(1'b1, 5'h04, 8'h08);
    rdc("pc", 5'h04, 8'h08);
    $display("test overcurrent done");
    wb(1'b1, 5'h0C, 8'h02);
    rdc("sl", 5'h0C, 8'h82);
    wb(1'b1, 5'h0C, 8'h01);
    tick(12);
    rdc("sl", 5'h0C, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 5'h0C, 8'(i));
      tick(12);
      chk("slew", i, slew_o);
    end
    $display("test slew done");
    wb(1'b1, 5'h05, 8'h00);
    chk("err", 1, ge);
    wb(1'b1, 5'h14, 8'hFF);
    rdc("st", 5'h14, 8'h00);
    wb(1'b1, 5'h04, 8'h0B);
    standby_i <= 1'b1;
    bus_wake_i <= 1'b1;
    tick(4);
    chk("wk", 1, wake_o);
    wb(1'b1, 5'h04, 8'h09);
    chk("wke", 0, wake_detect_en_o);
    wb(1'b1, 5'h04, 8'h01);
    chk("sd", 0, rx_enable_o | tx_enable_o | pullup_strong_o);
    for (int m = 0; m < 2; m++) begin
      factory_mode_i <= m[0];
      tick(3);
      wb(1'b1, 5'h08, 8'h5A);
      wb(1'b1, 5'h10, 8'hA5);
      rdc("ta", 5'h08, m ? 8'h5A : 8'h00);
      rdc("tb", 5'h10, m ? 8'hA5 : 8'h00);
      chk("tao", {24'h0, m ? 8'h5A : 8'h00}, {24'h0, test_a_o});
      chk("tbo", {24'h0, m ? 8'hA5 : 8'h00}, {24'h0, test_b_o});
    end
    $display("test misc done");
    finish_test();
  end
endmodule : lpc_regs_tb_top
bind lpc_regs lpc_regs_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
  .err_o, .overcurrent_i, .phy_tx_input_o, .tx_enable_o, .rx_enable_o, .pullup_strong_o, .wake_detect_en_o,
  .wake_o, .slew_o);
`default_nettype wire
